// File: rtl/sac_pkg.sv
// converter control package: register map, field layout, reset values, codes
// assumes a 32-bit apb bus and byte addressing of the register words
package sac_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SAC_OFS_STATUS = 8'h3C;
  localparam logic [7:0] SAC_OFS_RESULT = 8'h40;
  localparam logic [7:0] SAC_OFS_CLOCK = 8'h44;
  localparam logic [7:0] SAC_OFS_PORT_DATA = 8'h48;
  localparam logic [7:0] SAC_OFS_PORT_DIR = 8'h4C;
  localparam logic [7:0] SAC_OFS_PIN_READ = 8'h50;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SAC_BIT_DONE = 7;
  localparam int SAC_BIT_IRQ_EN = 6;
  localparam int SAC_BIT_CONT = 5;
  localparam int SAC_BIT_CLK_SRC = 4;
  localparam int SAC_PRESC_LSB = 5;
  localparam logic [7:0] SAC_STATUS_RST = 8'h1F;
  localparam logic [7:0] SAC_CLOCK_RST = 8'h00;
  localparam logic [3:0] SAC_PORT_RST = 4'h0;

  // ----------------------------------------------------------------
  // channel codes and conversion timing
  // ----------------------------------------------------------------
  localparam int SAC_NUM_PORT_CH = 4;
  localparam logic [4:0] SAC_CH_REFH = 5'h1D;
  localparam logic [4:0] SAC_CH_GND = 5'h1E;
  localparam logic [4:0] SAC_CH_OFF = 5'h1F;
  // 9 sample ticks plus 8 bit decisions give 17 converter clocks per result
  localparam logic [3:0] SAC_SAMPLE_TICKS = 4'h9;
  localparam logic [2:0] SAC_MSB_IDX = 3'h7;
  localparam logic [7:0] SAC_MSB_TRIAL = 8'h80;

  typedef struct packed {
    logic done;
    logic irq_en;
    logic cont;
    logic [4:0] chan;
  } sac_ctrl_t;

  typedef struct packed {
    logic [2:0] presc;
    logic bus_clk_sel;
    logic [3:0] rsvd;
  } sac_clkcfg_t;

endpackage : sac_pkg

// File: rtl/sac_sar_seq.sv
// successive-approximation sequencer: sample phase then msb-first decisions
// assumes one-cycle converter ticks and a compare input on the same clock
`timescale 1ns/1ps
`default_nettype none
module sac_sar_seq
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  // analog front end
  input wire logic cmp_i,
  output logic [7:0] trial_o,
  output logic sample_o,
  // status and result
  output logic busy_o,
  output logic done_o,
  output logic [7:0] result_o
);

  typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_RESOLVE} sac_seq_state_t;

  sac_seq_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [2:0] bit_ff;
  logic [7:0] sar_ff;
  logic [7:0] kept;

  // keep the trial bit when the input is at or above the trial level
  assign kept = cmp_i ? sar_ff : (sar_ff & ~(8'h01 << bit_ff));

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SAC_IDLE;
      cnt_ff <= 4'h0;
      bit_ff <= 3'h0;
      sar_ff <= 8'h00;
    end else if (start) begin
      state_ff <= SAC_SAMPLE;
      cnt_ff <= 4'h0;
      sar_ff <= 8'h00;
    end else if (abort) begin
      state_ff <= SAC_IDLE;
    end else if (tick) begin
      case (state_ff)
        SAC_SAMPLE: begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == SAC_SAMPLE_TICKS - 4'h1) begin
            state_ff <= SAC_RESOLVE;
            bit_ff <= SAC_MSB_IDX;
            sar_ff <= SAC_MSB_TRIAL;
          end
        end
        SAC_RESOLVE: begin
          if (bit_ff == 3'h0) begin
            state_ff <= SAC_IDLE;
            sar_ff <= kept;
          end else begin
            sar_ff <= kept | (8'h01 << (bit_ff - 3'h1));
            bit_ff <= bit_ff - 3'h1;
          end
        end
        default: state_ff <= SAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_o <= 1'b0;
      result_o <= 8'h00;
    end else begin
      done_o <= !start && !abort && tick && state_ff == SAC_RESOLVE && bit_ff == 3'h0;
      if (!start && !abort && tick && state_ff == SAC_RESOLVE && bit_ff == 3'h0) begin
        result_o <= kept;
      end
    end
  end

  assign trial_o = sar_ff;
  assign sample_o = (state_ff == SAC_SAMPLE);
  assign busy_o = (state_ff != SAC_IDLE);

  a_start_samples: assert property (@(posedge clk) disable iff (!rst_n)
    start |=> state_ff == SAC_SAMPLE && cnt_ff == 4'h0)
    else $error("start did not enter sampling");
  a_done_from_lsb: assert property (@(posedge clk) disable iff (!rst_n)
    done_o |-> $past(state_ff) == SAC_RESOLVE && $past(bit_ff) == 3'h0 && state_ff == SAC_IDLE)
    else $error("done without last bit decision");
  a_result_is_sar: assert property (@(posedge clk) disable iff (!rst_n)
    done_o |-> result_o == sar_ff)
    else $error("result differs from final approximation");

endmodule : sac_sar_seq
`default_nettype wire

// File: rtl/sac_top.sv
// converter control unit: apb registers, channel mux, pin override, flags
// assumes an apb master on pclk and an analog front end answering cmp_i
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module sac_top
  import sac_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clocks and power modes
  input wire logic osc_clk_i,
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  // analog front end
  input wire logic cmp_i,
  output logic [4:0] mux_sel_o,
  output logic adc_pwr_o,
  output logic sample_o,
  output logic [7:0] trial_o,
  // shared port pins
  input wire logic [3:0] pin_i,
  output logic [3:0] pin_o,
  output logic [3:0] pin_oe,
  // requests
  output logic cpu_irq_o,
  output logic dma_req_o,
  output logic wake_o
);

  // one-hot port pin taken over by the converter, none when powered off
  function automatic logic [3:0] port_take(input logic [4:0] chan);
    logic [3:0] hot;
    hot = 4'h0;
    if (chan < 5'(SAC_NUM_PORT_CH)) begin
      hot = 4'h1 << chan[1:0];
    end
    return hot;
  endfunction : port_take

  function automatic logic is_reg(input logic [7:0] a);
    return a == SAC_OFS_STATUS || a == SAC_OFS_RESULT || a == SAC_OFS_CLOCK ||
           a == SAC_OFS_PORT_DATA || a == SAC_OFS_PORT_DIR || a == SAC_OFS_PIN_READ;
  endfunction : is_reg

  sac_ctrl_t ctrl_ff;
  sac_clkcfg_t clkcfg_ff;
  logic [3:0] port_data_ff;
  logic [3:0] port_dir_ff;
  logic done_flag_ff;
  logic irq_pend_ff;
  logic resume_ff;
  logic stop_d_ff;
  logic [31:0] prdata_ff;
  logic [2:0] osc_sync_ff;
  logic osc_lvl_ff;
  logic osc_tick_ff;
  logic [3:0] div_cnt_ff;
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic [3:0] pin_s3_ff;
  logic [3:0] pin_stable_ff;

  logic acc;
  logic wr_status;
  logic rd_result;
  logic src_tick;
  logic conv_tick;
  logic [3:0] div_last;
  logic powered;
  logic start;
  logic abort;
  logic seq_busy;
  logic seq_done;
  logic [7:0] seq_result;
  logic [3:0] taken;
  logic [3:0] pin_read;
  logic [7:0] result_reg;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // no wait states: read data is loaded into a flop in the setup phase
  assign acc = psel && penable;
  assign pready = acc;
  assign pslverr = acc && !is_reg(paddr);
  assign prdata = prdata_ff;
  assign wr_status = acc && pwrite && paddr == SAC_OFS_STATUS;
  assign rd_result = acc && !pwrite && paddr == SAC_OFS_RESULT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        SAC_OFS_STATUS: begin
          // with interrupts on, the completion bit is the request-type select
          prdata_ff <= {24'h00_0000, (ctrl_ff.irq_en ? ctrl_ff.done : done_flag_ff),
                        ctrl_ff.irq_en, ctrl_ff.cont, ctrl_ff.chan};
        end
        SAC_OFS_RESULT: prdata_ff <= {24'h00_0000, result_reg};
        SAC_OFS_CLOCK: prdata_ff <= {24'h00_0000, clkcfg_ff.presc, clkcfg_ff.bus_clk_sel, 4'h0};
        SAC_OFS_PORT_DATA: prdata_ff <= {28'h000_0000, port_data_ff};
        SAC_OFS_PORT_DIR: prdata_ff <= {28'h000_0000, port_dir_ff};
        SAC_OFS_PIN_READ: prdata_ff <= {28'h000_0000, pin_read};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= sac_ctrl_t'(SAC_STATUS_RST);
      clkcfg_ff <= sac_clkcfg_t'(SAC_CLOCK_RST);
    end else if (acc && pwrite) begin
      if (paddr == SAC_OFS_STATUS) begin
        ctrl_ff <= sac_ctrl_t'(pwdata[7:0]);
      end
      if (paddr == SAC_OFS_CLOCK) begin
        clkcfg_ff <= sac_clkcfg_t'({pwdata[7:4], 4'h0});
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_ff <= SAC_PORT_RST;
      port_dir_ff <= SAC_PORT_RST;
    end else if (acc && pwrite) begin
      if (paddr == SAC_OFS_PORT_DATA) begin
        port_data_ff <= pwdata[3:0];
      end
      if (paddr == SAC_OFS_PORT_DIR) begin
        port_dir_ff <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // converter clock: source select and prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync_ff <= 3'h0;
      osc_lvl_ff <= 1'b0;
      osc_tick_ff <= 1'b0;
    end else begin
      osc_sync_ff <= {osc_sync_ff[1:0], osc_clk_i};
      osc_tick_ff <= 1'b0;
      if (osc_sync_ff[1] == osc_sync_ff[2] && osc_sync_ff[2] != osc_lvl_ff) begin
        osc_lvl_ff <= osc_sync_ff[2];
        osc_tick_ff <= osc_sync_ff[2];
      end
    end
  end

  assign src_tick = clkcfg_ff.bus_clk_sel ? 1'b1 : osc_tick_ff;
  assign div_last = clkcfg_ff.presc[2] ? 4'hF : ((4'h1 << clkcfg_ff.presc[1:0]) - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 4'h0;
    end else if (start) begin
      div_cnt_ff <= 4'h0;
    end else if (src_tick) begin
      div_cnt_ff <= (div_cnt_ff >= div_last) ? 4'h0 : div_cnt_ff + 4'h1;
    end
  end

  assign conv_tick = src_tick && div_cnt_ff >= div_last;

  // ----------------------------------------------------------------
  // conversion control
  // ----------------------------------------------------------------
  assign powered = ctrl_ff.chan != SAC_CH_OFF;
  assign adc_pwr_o = powered && !stop_mode_i;
  assign mux_sel_o = ctrl_ff.chan;
  // a write lands a cycle before ctrl_ff shows it, so restart from the bus data
  assign start = (wr_status && pwdata[4:0] != SAC_CH_OFF && !stop_mode_i) ||
                 (seq_done && ctrl_ff.cont && !wr_status && !stop_mode_i) ||
                 (stop_d_ff && !stop_mode_i && resume_ff);
  assign abort = stop_mode_i || (wr_status && pwdata[4:0] == SAC_CH_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_d_ff <= 1'b0;
      resume_ff <= 1'b0;
    end else begin
      stop_d_ff <= stop_mode_i;
      if (stop_mode_i && !stop_d_ff) begin
        resume_ff <= powered && (seq_busy || ctrl_ff.cont);
      end else if (wr_status) begin
        // judge the newly written channel, the register still holds the old one
        resume_ff <= pwdata[4:0] != SAC_CH_OFF;
      end
    end
  end

  // wait mode gates nothing here: conversions go on and requests still rise
  sac_sar_seq u_seq (
    .clk(pclk),
    .rst_n(presetn),
    .tick(conv_tick),
    .start(start),
    .abort(abort),
    .cmp_i(cmp_i),
    .trial_o(trial_o),
    .sample_o(sample_o),
    .busy_o(seq_busy),
    .done_o(seq_done),
    .result_o(seq_result)
  );
  assign result_reg = seq_result;

  // ----------------------------------------------------------------
  // completion flag and requests
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag_ff <= 1'b0;
    end else if (seq_done && !ctrl_ff.irq_en) begin
      done_flag_ff <= 1'b1;
    end else if (wr_status || rd_result) begin
      done_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_ff <= 1'b0;
    end else if (seq_done && ctrl_ff.irq_en) begin
      irq_pend_ff <= 1'b1;
    end else if (wr_status || rd_result) begin
      irq_pend_ff <= 1'b0;
    end
  end

  // completion bit set with interrupts on steers to a dma request nobody serves
  assign cpu_irq_o = irq_pend_ff && ctrl_ff.irq_en && !ctrl_ff.done;
  assign dma_req_o = irq_pend_ff && ctrl_ff.irq_en && ctrl_ff.done;
  assign wake_o = cpu_irq_o && wait_mode_i;

  // ----------------------------------------------------------------
  // shared port pins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
      pin_s3_ff <= 4'h0;
      pin_stable_ff <= 4'h0;
    end else begin
      pin_s1_ff <= pin_i;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_stable_ff <= (pin_s2_ff & ~(pin_s2_ff ^ pin_s3_ff)) |
                       (pin_stable_ff & (pin_s2_ff ^ pin_s3_ff));
    end
  end

  assign taken = port_take(ctrl_ff.chan);

  genvar gi;
  generate
    for (gi = 0; gi < SAC_NUM_PORT_CH; gi++) begin : g_pin
      assign pin_o[gi] = port_data_ff[gi];
      assign pin_oe[gi] = port_dir_ff[gi] && !taken[gi];
      assign pin_read[gi] = port_dir_ff[gi] ? port_data_ff[gi] :
                            (taken[gi] ? 1'b0 : pin_stable_ff[gi]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_write_restarts: assert property (@(posedge pclk) disable iff (!presetn)
    wr_status && pwdata[4:0] != SAC_CH_OFF && !stop_mode_i |=> seq_busy)
    else $error("control write did not start a conversion");
  a_off_idles: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff.chan == SAC_CH_OFF && !$past(seq_done) |-> !seq_busy && !adc_pwr_o)
    else $error("converter active while powered off");
  a_flag_on_done: assert property (@(posedge pclk) disable iff (!presetn)
    seq_done && !ctrl_ff.irq_en |=> done_flag_ff)
    else $error("done flag not set at end of conversion");
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    done_flag_ff && rd_result && !seq_done |=> !done_flag_ff)
    else $error("done flag not cleared by result read");
  a_irq_kind: assert property (@(posedge pclk) disable iff (!presetn)
    seq_done && ctrl_ff.irq_en |=> (cpu_irq_o != ctrl_ff.done) && (dma_req_o == ctrl_ff.done))
    else $error("wrong request type after conversion");
  a_stop_aborts: assert property (@(posedge pclk) disable iff (!presetn)
    stop_mode_i |=> !seq_busy && !seq_done)
    else $error("conversion survived stop mode");
  a_pin_forced: assert property (@(posedge pclk) disable iff (!presetn)
    taken != 4'h0 |-> (pin_oe & taken) == 4'h0)
    else $error("selected pin still driven by port");
  a_single_shot: assert property (@(posedge pclk) disable iff (!presetn)
    seq_done && !ctrl_ff.cont && !wr_status && !stop_d_ff |=> !seq_busy)
    else $error("single mode converted again");
  a_cont_restart: assert property (@(posedge pclk) disable iff (!presetn)
    seq_done && ctrl_ff.cont && !wr_status && !stop_mode_i |=> seq_busy)
    else $error("continuous mode did not restart");
  a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
    irq_pend_ff && (wr_status || rd_result) && !seq_done |=> !cpu_irq_o && !dma_req_o)
    else $error("request not dropped by result read or control write");
  a_wake_in_wait: assert property (@(posedge pclk) disable iff (!presetn)
    seq_done && ctrl_ff.irq_en && !ctrl_ff.done && wait_mode_i |=> wake_o)
    else $error("conversion end did not wake from wait");
  a_prescale_gap: assert property (@(posedge pclk) disable iff (!presetn)
    conv_tick && clkcfg_ff.bus_clk_sel && clkcfg_ff.presc == 3'h3 |=> !conv_tick [*7])
    else $error("converter tick faster than divide by eight");
  a_pin_read_forced: assert property (@(posedge pclk) disable iff (!presetn)
    taken != 4'h0 |-> (pin_read & taken) == (port_dir_ff & port_data_ff & taken))
    else $error("converter pin read not forced");

endmodule : sac_top
`default_nettype wire

// File: sim/sac_front_model.sv
// analog front end model: channel mux and comparator seen by the sequencer
// assumes the converter drives mux select, power and trial on pclk
`timescale 1ns/1ps
`default_nettype none
module sac_front_model
  import sac_pkg::*;
(
  // clock
  input wire logic pclk,
  // converter side
  input wire logic [4:0] mux_sel_o,
  input wire logic adc_pwr_o,
  input wire logic [7:0] trial_o,
  input wire logic [31:0] level_i,
  output logic cmp_i
);
  logic [7:0] vin;
  logic toggle_ff = 1'b0;

  always_comb begin
    case (mux_sel_o)
      SAC_CH_REFH: vin = 8'hFF;
      SAC_CH_GND: vin = 8'h00;
      5'h00, 5'h01, 5'h02, 5'h03: vin = level_i[8*mux_sel_o +: 8];
      // unused codes give a level that nobody may rely on
      default: vin = trial_o ^ 8'hA5;
    endcase
  end

  // an unpowered comparator gives a changing level, never a clean 0
  always @(posedge pclk) toggle_ff <= ~toggle_ff;
  assign cmp_i = adc_pwr_o ? (vin >= trial_o) : toggle_ff;
endmodule : sac_front_model
`default_nettype wire

// File: sim/sac_top_tb.sv
// bench for the converter control unit: apb tasks and directed tests
// assumes sac_top and the front end model, pclk 50 ns, oscillator 200 ns
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(g, e)
module sac_top_tb;
  import sac_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc = 0;
  logic wait_m = 0, stop_m = 0, err, cmp, pready, pslverr, pwr, smp, irq, dma, wake;
  logic [7:0] paddr = 8'h00, trial;
  logic [31:0] pwdata = 32'h0, prdata, rd, lvl = 32'hC35A0FA5;
  logic [4:0] msel;
  logic [3:0] pin_o, pin_oe, ext = 4'h0;
  wire logic [3:0] pin_i;
  logic [4:0] chans [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1D, 5'h1E};
  logic [2:0] pcs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int divs [6] = '{1, 2, 4, 8, 16, 16};
  int n_mismatch = 0, checks_done = 0, cyc, n;

  always #25 pclk = ~pclk;
  always #100 osc = ~osc;
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);

  sac_top i_sac_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_clk_i(osc), .wait_mode_i(wait_m), .stop_mode_i(stop_m),
    .cmp_i(cmp), .mux_sel_o(msel), .adc_pwr_o(pwr), .sample_o(smp), .trial_o(trial),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .cpu_irq_o(irq), .dma_req_o(dma),
    .wake_o(wake));
  sac_front_model i_sac_front_model (.pclk(pclk), .mux_sel_o(msel), .adc_pwr_o(pwr),
    .trial_o(trial), .level_i(lvl), .cmp_i(cmp));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin n_mismatch++; results(); end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  // counts negedges after the last write edge until a request shows
  task automatic wait_req(input int lim);
    cyc = 0;
    do begin @(negedge pclk); cyc++; end while (irq !== 1 && dma !== 1 && cyc < lim);
    if (cyc >= lim) begin n_mismatch++; results(); end
  endtask : wait_req

  function automatic logic [7:0] lv(input logic [4:0] c);
    if (c < 5'h04) return lvl[8*c +: 8];
    return (c == SAC_CH_REFH) ? 8'hFF : 8'h00;
  endfunction : lv

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, SAC_OFS_STATUS, 8'h00); `CHK(rd, 32'h1F);
    `CHK(pwr, 1'b0);
    apb(0, SAC_OFS_CLOCK, 8'h00); `CHK(rd, 32'h0);
    apb(0, SAC_OFS_RESULT, 8'h00); `CHK(rd, 32'h0);
    apb(0, 8'h20, 8'h00); `CHK(err, 1'b1);
    `CHK(rd, 32'h0);
    $display("test reset done");
    apb(1, SAC_OFS_CLOCK, 8'h10);
    for (int i = 0; i < 6; i++) begin
      apb(1, SAC_OFS_STATUS, {3'h0, chans[i]});
      @(negedge pclk); `CHK({pwr, smp, msel}, {2'b11, chans[i]});
      n = 0;
      do begin apb(0, SAC_OFS_STATUS, 8'h00); n++; end while (rd[7] !== 1 && n < 40);
      `CHK(rd[7], 1'b1);
      apb(0, SAC_OFS_RESULT, 8'h00); `CHK(rd, lv(chans[i]));
      apb(0, SAC_OFS_STATUS, 8'h00); `CHK(rd[7], 1'b0);
    end
    apb(1, SAC_OFS_STATUS, 8'h00);
    repeat (30) @(posedge pclk);
    apb(1, SAC_OFS_STATUS, 8'h1F);
    @(negedge pclk); `CHK(pwr, 1'b0);
    apb(0, SAC_OFS_STATUS, 8'h00); `CHK(rd, 32'h1F);
    apb(1, SAC_OFS_RESULT, 8'h11);
    apb(0, SAC_OFS_RESULT, 8'h00); `CHK(rd, lv(0));
    $display("test channels done");
    for (int i = 0; i < 6; i++) begin
      apb(1, SAC_OFS_CLOCK, {pcs[i], 5'h10});
      wait_m <= (i == 1);
      apb(1, SAC_OFS_STATUS, 8'h41);
      wait_req(600);
      `CHK(cyc >= 16 * divs[i] && cyc <= 17 * divs[i] + 3, 1'b1);
      `CHK({dma, irq, wake}, {2'b01, i == 1});
      apb(0, SAC_OFS_RESULT, 8'h00); `CHK(rd, lv(1));
      @(negedge pclk); `CHK(irq, 1'b0);
    end
    apb(1, SAC_OFS_CLOCK, 8'h00);
    apb(1, SAC_OFS_STATUS, 8'h42);
    wait_req(200); `CHK(cyc >= 64 && cyc <= 80, 1'b1);
    apb(0, SAC_OFS_RESULT, 8'h00); `CHK(rd, lv(2));
    $display("test clocks done");
    apb(1, SAC_OFS_CLOCK, 8'h10);
    apb(1, SAC_OFS_STATUS, 8'hC0);
    wait_req(100); `CHK({dma, irq}, 2'b10);
    apb(1, SAC_OFS_STATUS, 8'h40);
    @(negedge pclk); `CHK(dma, 1'b0);
    wait_req(100); `CHK({dma, irq}, 2'b01);
    apb(0, SAC_OFS_RESULT, 8'h00);
    $display("test request type done");
    apb(1, SAC_OFS_STATUS, 8'h1F);
    apb(1, SAC_OFS_STATUS, 8'h60);
    // first result after power-up is only for settling
    wait_req(100);
    lvl[7:0] = 8'h3C;
    repeat (50) @(posedge pclk);
    apb(0, SAC_OFS_RESULT, 8'h00); `CHK(rd, 32'h3C);
    wait_req(100); `CHK(irq, 1'b1);
    apb(1, SAC_OFS_STATUS, 8'h40);
    wait_req(100);
    apb(0, SAC_OFS_RESULT, 8'h00);
    lvl[7:0] = 8'h96;
    repeat (60) @(negedge pclk); `CHK(irq, 1'b0);
    apb(0, SAC_OFS_RESULT, 8'h00); `CHK(rd, 32'h3C);
    $display("test continuous done");
    apb(1, SAC_OFS_STATUS, 8'h40);
    repeat (5) @(posedge pclk);
    apb(1, SAC_OFS_STATUS, 8'h43);
    wait_req(100); `CHK(cyc >= 16, 1'b1);
    apb(0, SAC_OFS_RESULT, 8'h00); `CHK(rd, lv(3));
    apb(1, SAC_OFS_STATUS, 8'h42);
    repeat (5) @(posedge pclk);
    stop_m <= 1'b1;
    repeat (2) @(negedge pclk); `CHK(pwr, 1'b0);
    repeat (60) @(negedge pclk); `CHK(irq, 1'b0);
    @(posedge pclk);
    stop_m <= 1'b0;
    wait_req(100);
    apb(0, SAC_OFS_RESULT, 8'h00); `CHK(rd, lv(2));
    $display("test restart and stop done");
    apb(1, SAC_OFS_PORT_DATA, 8'h0F);
    apb(1, SAC_OFS_PORT_DIR, 8'h0F);
    apb(1, SAC_OFS_STATUS, 8'h02);
    @(negedge pclk); `CHK(pin_oe, 4'hB);
    apb(0, SAC_OFS_PIN_READ, 8'h00); `CHK(rd, 32'h0F);
    apb(1, SAC_OFS_PORT_DIR, 8'h00);
    ext <= 4'hF;
    repeat (4) @(posedge pclk);
    apb(0, SAC_OFS_PIN_READ, 8'h00); `CHK(rd, 32'h0B);
    apb(1, SAC_OFS_PORT_DIR, 8'h04);
    @(negedge pclk); `CHK(pin_oe, 4'h0);
    apb(1, SAC_OFS_STATUS, 8'h05);
    @(negedge pclk); `CHK({pwr, smp, pin_oe}, 6'h34);
    apb(1, SAC_OFS_STATUS, 8'h1F);
    @(negedge pclk); `CHK(pin_oe, 4'h4);
    $display("test port pins done");
    results();
  end
endmodule : sac_top_tb
`default_nettype wire
